/* hdl/rcba_pkg.sv */
// shared constants and types for the real compare / bcd add unit
package rcba_pkg;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned DWORD_W = 32;
    localparam int unsigned NIBBLES = 8;
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    localparam logic [3:0] BCD_ADJUST = 4'h6;
    localparam logic [7:0] REAL_EXP_ALL_ONES = 8'hFF;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam int unsigned EXEC_CYCLES = 1;

    // operation select
    typedef enum logic [1:0] {
        RCBA_OP_NONE,
        RCBA_OP_CMP_REAL,
        RCBA_OP_ADD_BCD,
        RCBA_OP_ADD_DBCD
    } rcba_op_t;

    // operand source
    typedef enum logic [1:0] {
        RCBA_SRC_MEM,
        RCBA_SRC_PTR,
        RCBA_SRC_CONST
    } rcba_src_t;
endpackage

/* hdl/rcba_bcd_adder.sv */
// 8-digit bcd adder with digit validity check and carry taps
`timescale 1ns/100ps
module rcba_bcd_adder #(
    parameter int unsigned DIGITS = 8
) (
    // operands
    input wire logic [4*DIGITS-1:0] a_i,
    input wire logic [4*DIGITS-1:0] b_i,
    // results
    output logic [4*DIGITS-1:0] sum_o,
    output logic carry_16_o,
    output logic carry_32_o,
    output logic bad_digit_o
);
    logic [DIGITS:0] carry;
    logic [DIGITS-1:0] bad;

    assign carry[0] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : gen_digit
            logic [4:0] raw;
            assign raw = {1'b0, a_i[4*g+:4]} + {1'b0, b_i[4*g+:4]} + {4'h0, carry[g]};
            assign carry[g+1] = (raw > {1'b0, rcba_pkg::BCD_MAX_DIGIT});
            assign sum_o[4*g+:4] = carry[g+1] ? 4'(raw + {1'b0, rcba_pkg::BCD_ADJUST}) : raw[3:0];
            assign bad[g] = (a_i[4*g+:4] > rcba_pkg::BCD_MAX_DIGIT)
                          | (b_i[4*g+:4] > rcba_pkg::BCD_MAX_DIGIT);
        end
    endgenerate

    assign carry_16_o = carry[DIGITS/2];
    assign carry_32_o = carry[DIGITS];
    assign bad_digit_o = |bad;
endmodule

/* hdl/rcba_real_cmp.sv */
// ieee single compare with not-a-number detection
`timescale 1ns/100ps
module rcba_real_cmp (
    // operands
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    // results
    output logic lt_o,
    output logic eq_o,
    output logic gt_o,
    output logic bad_o
);
    logic a_nan;
    logic b_nan;
    logic a_zero;
    logic b_zero;
    logic mag_lt;
    logic mag_eq;

    assign a_nan = (a_i[30:23] == rcba_pkg::REAL_EXP_ALL_ONES) && (a_i[22:0] != 23'h000000);
    assign b_nan = (b_i[30:23] == rcba_pkg::REAL_EXP_ALL_ONES) && (b_i[22:0] != 23'h000000);
    assign a_zero = (a_i[30:0] == 31'h00000000);
    assign b_zero = (b_i[30:0] == 31'h00000000);
    assign mag_lt = a_i[30:0] < b_i[30:0];
    assign mag_eq = a_i[30:0] == b_i[30:0];
    assign bad_o = a_nan | b_nan;

    // +0 and -0 compare equal; sign-magnitude ordering otherwise
    always_comb begin
        lt_o = 1'b0;
        eq_o = 1'b0;
        gt_o = 1'b0;
        if (bad_o) begin
            // unordered: no relation flag
        end else if ((a_zero && b_zero) || (a_i == b_i)) begin
            eq_o = 1'b1;
        end else if (a_i[31] != b_i[31]) begin
            lt_o = a_i[31];
            gt_o = b_i[31];
        end else if (a_i[31]) begin
            lt_o = !mag_lt && !mag_eq;
            gt_o = mag_lt;
        end else begin
            lt_o = mag_lt;
            gt_o = !mag_lt && !mag_eq;
        end
    end
endmodule

/* hdl/rcba_unit.sv */
// real compare and bcd add accumulator unit with status flags
// Contract
// - real compare: 32-bit accumulator versus 32-bit operand
// - accumulator smaller sets less-than flag
// - exact match sets equality flag
// - accumulator larger sets greater-than flag
// - invalid pointer target sets bad-pointer flag
// - non-real operand sets bad-operand-format flag
// - flags hold until next affecting instruction
// - single add: low accumulator plus 16-bit operand (code adds the low memory word, even for a constant source)
// - double add: 32-bit accumulator plus operand
// - zero result sets zero flag
// - carry out of digit four sets carry16
// - carry out of digit eight sets carry32
// - negative accumulator sets negative flag
// - non-decimal nibble sets bad-operand-format flag
`timescale 1ns/100ps
module rcba_unit (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // issue from the sequencer
    input wire logic op_valid_i,
    input wire rcba_pkg::rcba_op_t op_i,
    input wire rcba_pkg::rcba_src_t src_i,
    // operand words from variable memory, or a constant
    input wire logic [15:0] mem_lo_word_i,
    input wire logic [15:0] mem_hi_word_i,
    input wire logic [31:0] const_i,
    input wire logic ptr_invalid_i,
    // accumulator load from the rest of the cpu
    input wire logic acc_load_i,
    input wire logic [31:0] acc_load_data_i,
    // accumulator and completion
    output logic [31:0] acc_o,
    output logic done_o,
    // discrete status flags
    output logic flag_less_than_o,
    output logic flag_equal_o,
    output logic flag_greater_than_o,
    output logic flag_zero_o,
    output logic flag_carry_16_o,
    output logic flag_carry_32_o,
    output logic flag_negative_o,
    output logic flag_bad_pointer_o,
    output logic flag_bad_operand_format_o
);
    typedef struct packed {
        logic [31:0] acc;
        logic done;
        logic flag_less_than;
        logic flag_equal;
        logic flag_greater_than;
        logic flag_zero;
        logic flag_carry_16;
        logic flag_carry_32;
        logic flag_negative;
        logic flag_bad_pointer;
        logic flag_bad_operand_format;
    } rcba_state_t;

    rcba_state_t st;
    rcba_state_t next_st;

    logic [31:0] operand;
    logic [31:0] add_b;
    logic [31:0] bcd_sum;
    logic carry_16;
    logic carry_32;
    logic bcd_bad;
    logic cmp_lt;
    logic cmp_eq;
    logic cmp_gt;
    logic cmp_bad;

    // two adjacent words: lower address is the low half
    always_comb begin
        if (src_i == rcba_pkg::RCBA_SRC_CONST) begin
            operand = const_i;
        end else begin
            operand = {mem_hi_word_i, mem_lo_word_i};
        end
    end

    // single add sees only the low halves; upper digits zero
    always_comb begin
        if (op_i == rcba_pkg::RCBA_OP_ADD_BCD) begin
            add_b = {16'h0000, mem_lo_word_i};
        end else begin
            add_b = operand;
        end
    end

    rcba_bcd_adder #(
        .DIGITS(rcba_pkg::NIBBLES)
    ) u_adder (
        .a_i((op_i == rcba_pkg::RCBA_OP_ADD_BCD) ? {16'h0000, st.acc[15:0]} : st.acc),
        .b_i(add_b),
        .sum_o(bcd_sum),
        .carry_16_o(carry_16),
        .carry_32_o(carry_32),
        .bad_digit_o(bcd_bad)
    );

    rcba_real_cmp u_cmp (
        .a_i(st.acc),
        .b_i(operand),
        .lt_o(cmp_lt),
        .eq_o(cmp_eq),
        .gt_o(cmp_gt),
        .bad_o(cmp_bad)
    );

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (acc_load_i) begin
            next_st.acc = acc_load_data_i;
        end
        // flags change only when an instruction that owns them runs
        if (op_valid_i) begin
            next_st.done = 1'b1;
            next_st.flag_bad_pointer = (src_i == rcba_pkg::RCBA_SRC_PTR) && ptr_invalid_i;
            unique case (op_i)
                rcba_pkg::RCBA_OP_CMP_REAL: begin
                    // accumulator left untouched by a compare
                    next_st.flag_less_than = cmp_lt;
                    next_st.flag_equal = cmp_eq;
                    next_st.flag_greater_than = cmp_gt;
                    next_st.flag_bad_operand_format = cmp_bad;
                end
                rcba_pkg::RCBA_OP_ADD_BCD,
                rcba_pkg::RCBA_OP_ADD_DBCD: begin
                    // a bad pointer target or bad digit leaves the accumulator intact
                    if (!next_st.flag_bad_pointer && !bcd_bad) begin
                        if (op_i == rcba_pkg::RCBA_OP_ADD_BCD) begin
                            next_st.acc = {16'h0000, bcd_sum[15:0]};
                        end else begin
                            next_st.acc = bcd_sum;
                        end
                    end
                    next_st.flag_zero = (next_st.acc == 32'h0000_0000);
                    next_st.flag_carry_16 = carry_16 && !bcd_bad;
                    next_st.flag_carry_32 = (op_i == rcba_pkg::RCBA_OP_ADD_DBCD)
                                          && carry_32 && !bcd_bad;
                    next_st.flag_negative = next_st.acc[31];
                    next_st.flag_bad_operand_format = bcd_bad;
                end
                rcba_pkg::RCBA_OP_NONE: begin
                    next_st.done = 1'b0;
                    next_st.flag_bad_pointer = st.flag_bad_pointer;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
            st.acc <= rcba_pkg::ACC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign acc_o = st.acc;
    assign done_o = st.done;
    assign flag_less_than_o = st.flag_less_than;
    assign flag_equal_o = st.flag_equal;
    assign flag_greater_than_o = st.flag_greater_than;
    assign flag_zero_o = st.flag_zero;
    assign flag_carry_16_o = st.flag_carry_16;
    assign flag_carry_32_o = st.flag_carry_32;
    assign flag_negative_o = st.flag_negative;
    assign flag_bad_pointer_o = st.flag_bad_pointer;
    assign flag_bad_operand_format_o = st.flag_bad_operand_format;
endmodule

/* test/rcba_mem_model.sv */
// variable memory model feeding operand words to the unit
`timescale 1ns/100ps
module rcba_mem_model (
    // word address
    input wire logic [3:0] addr_i,
    // operand words and pointer check
    output logic [15:0] lo_word_o,
    output logic [15:0] hi_word_o,
    output logic ptr_bad_o
);
    logic [15:0] mem [16];
    // upper half stands for unmapped pointer targets
    assign ptr_bad_o = addr_i[3];
    assign lo_word_o = mem[addr_i];
    assign hi_word_o = mem[addr_i+4'h1];
    initial begin
        mem = '{1: 16'h40C0, 3: 16'h4100, 4: 16'h0001, 5: 16'h0002, default: 16'h0000};
    end
endmodule

/* test/rcba_unit_asserts.sv */
// port assertions for the accumulator unit
`timescale 1ns/100ps
module rcba_unit_chk (
    // clock, reset and issue
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic op_valid_i,
    input wire rcba_pkg::rcba_op_t op_i,
    input wire rcba_pkg::rcba_src_t src_i,
    input wire logic ptr_invalid_i,
    input wire logic acc_load_i,
    // results
    input wire logic [31:0] acc_o,
    input wire logic done_o,
    input wire logic flag_less_than_o,
    input wire logic flag_equal_o,
    input wire logic flag_greater_than_o,
    input wire logic flag_zero_o,
    input wire logic flag_carry_32_o,
    input wire logic flag_negative_o,
    input wire logic flag_bad_pointer_o,
    input wire logic flag_bad_operand_format_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic go, cmp, one, add, bad;
    assign go = op_valid_i && op_i != rcba_pkg::RCBA_OP_NONE;
    assign cmp = go && op_i == rcba_pkg::RCBA_OP_CMP_REAL;
    assign one = go && op_i == rcba_pkg::RCBA_OP_ADD_BCD;
    assign add = one || (go && op_i == rcba_pkg::RCBA_OP_ADD_DBCD);
    assign bad = flag_bad_operand_format_o || flag_bad_pointer_o;
    done_pulse_a: assert property (go |=> done_o) else $error("done missing");
    done_idle_a: assert property (!go |=> !done_o) else $error("done spurious");
    cmp_onehot_a: assert property (cmp && src_i != rcba_pkg::RCBA_SRC_PTR |=>
        flag_bad_operand_format_o ||
        $onehot({flag_less_than_o, flag_equal_o, flag_greater_than_o})) else $error("cmp flags");
    acc_keep_a: assert property (!add && !acc_load_i |=> $stable(acc_o)) else $error("acc moved");
    neg_track_a: assert property (add |=> flag_negative_o == acc_o[31]) else $error("neg");
    zero_track_a: assert property (add |=> bad || flag_zero_o == (acc_o == 32'h0))
        else $error("zero");
    ptr_flag_a: assert property (go && src_i == rcba_pkg::RCBA_SRC_PTR && ptr_invalid_i
        |=> flag_bad_pointer_o) else $error("bad pointer");
    single_add_a: assert property (one |=> !flag_carry_32_o && (bad || acc_o[31:16] == 16'h0))
        else $error("single add");
    cover property (done_o && flag_greater_than_o);
    cover property (flag_carry_32_o);
    cover property (flag_bad_pointer_o);
endmodule

bind rcba_unit rcba_unit_chk u_chk (.*);

/* test/rcba_unit_bench.sv */
// self-checking bench for the accumulator unit
`timescale 1ns/100ps
module rcba_unit_bench;
    localparam rcba_pkg::rcba_op_t NON = rcba_pkg::RCBA_OP_NONE;
    localparam rcba_pkg::rcba_op_t CMP = rcba_pkg::RCBA_OP_CMP_REAL;
    localparam rcba_pkg::rcba_op_t AB = rcba_pkg::RCBA_OP_ADD_BCD;
    localparam rcba_pkg::rcba_op_t AD = rcba_pkg::RCBA_OP_ADD_DBCD;
    localparam rcba_pkg::rcba_src_t MEM = rcba_pkg::RCBA_SRC_MEM;
    localparam rcba_pkg::rcba_src_t PTR = rcba_pkg::RCBA_SRC_PTR;
    localparam rcba_pkg::rcba_src_t KON = rcba_pkg::RCBA_SRC_CONST;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic vld = 1'b0;
    rcba_pkg::rcba_op_t op = NON;
    rcba_pkg::rcba_src_t src = MEM;
    logic [3:0] addr = 4'h0;
    logic [31:0] k = 32'h0;
    logic ld = 1'b0;
    logic [31:0] ldd = 32'h0;
    logic [15:0] lo;
    logic [15:0] hi;
    logic pbad;
    logic done;
    logic [31:0] acc;
    logic [8:0] fl;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    rcba_mem_model u_mem (.addr_i(addr), .lo_word_o(lo), .hi_word_o(hi), .ptr_bad_o(pbad));
    rcba_unit u_dut (.sys_clk_i(clk), .nrst_i(nrst), .op_valid_i(vld), .op_i(op), .src_i(src),
        .mem_lo_word_i(lo), .mem_hi_word_i(hi), .const_i(k), .ptr_invalid_i(pbad),
        .acc_load_i(ld), .acc_load_data_i(ldd), .acc_o(acc), .done_o(done),
        .flag_less_than_o(fl[8]), .flag_equal_o(fl[7]), .flag_greater_than_o(fl[6]),
        .flag_zero_o(fl[5]), .flag_carry_16_o(fl[4]), .flag_carry_32_o(fl[3]),
        .flag_negative_o(fl[2]), .flag_bad_pointer_o(fl[1]), .flag_bad_operand_format_o(fl[0]));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // load the accumulator, issue one op the next cycle, check masked flags
    task automatic step(input rcba_pkg::rcba_op_t o, input rcba_pkg::rcba_src_t s,
            input logic [3:0] a, input logic [31:0] c, input logic [31:0] v,
            input logic [31:0] ea, input logic [8:0] ef, input logic [8:0] m);
        @(posedge clk);
        ld <= 1'b1;
        ldd <= v;
        @(posedge clk);
        ld <= 1'b0;
        vld <= 1'b1;
        op <= o;
        src <= s;
        addr <= a;
        k <= c;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk("done", {31'h0, o != NON}, {31'h0, done});
        chk("acc", ea, acc);
        chk("flags", {23'h0, ef & m}, {23'h0, fl & m});
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // run needs about 41 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 400) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("reset", 32'h0, {acc[22:0], fl});
        step(CMP, MEM, 4'h0, 32'h0, 32'h40E00000, 32'h40E00000, 9'h040, 9'h1C3);
        step(CMP, KON, 4'h0, 32'h40E00000, 32'h40E00000, 32'h40E00000, 9'h080, 9'h1C3);
        step(CMP, PTR, 4'h2, 32'h0, 32'h40E00000, 32'h40E00000, 9'h100, 9'h1C3);
        step(CMP, KON, 4'h0, 32'h7FC00000, 32'h40E00000, 32'h40E00000, 9'h001, 9'h1C3);
        step(CMP, PTR, 4'h8, 32'h0, 32'h40E00000, 32'h40E00000, 9'h002, 9'h002);
        step(AB, MEM, 4'h4, 32'h0, 32'h00009999, 32'h0, 9'h030, 9'h03F);
        step(AB, PTR, 4'h5, 32'h0, 32'h12349999, 32'h1, 9'h010, 9'h03F);
        step(AD, KON, 4'h0, 32'h1, 32'h99999999, 32'h0, 9'h038, 9'h03F);
        step(AD, KON, 4'h0, 32'h0, 32'h80000000, 32'h80000000, 9'h004, 9'h03F);
        step(CMP, MEM, 4'h0, 32'h0, 32'h40E00000, 32'h40E00000, 9'h044, 9'h1FF);
        step(AD, KON, 4'h0, 32'h1, 32'h0000000A, 32'h0000000A, 9'h001, 9'h001);
        step(AB, PTR, 4'h8, 32'h0, 32'h00001234, 32'h00001234, 9'h002, 9'h002);
        step(NON, MEM, 4'h0, 32'h0, 32'h00000055, 32'h00000055, 9'h0, 9'h0);
        final_report();
    end
endmodule
